/* File: chain_status.sv */
/*
 * One chained switch: safe/unsafe decision, safety output pair, pulsed
 * diagnostic status line and actuator recognition with pairing.
 * Assumes the sense and pairing pins come from outside and are synchronised here;
 * upstream status arrives as a position of the first unsafe switch.
 */
`default_nettype none

module chain_status
    import chain_pkg::*;
#(
    parameter int SLOT_CYCLES = SLOT_CYC,
    parameter int FRAME_SLOTS = MAX_CHAIN,
    parameter logic [CODE_W-1:0] FACTORY_CODE = 32'h5a5a_0001, // arbitrary value
    parameter logic [CODE_W-1:0] GENERIC_CODE = 32'h0bad_c0de // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire variant_e variant,
    input wire logic [POS_W-1:0] chain_pos,
    input wire logic [POS_W-1:0] upstream_unsafe_pos,
    input wire logic upstream_unsafe,
    input wire logic in_operating_range,
    input wire logic beyond_release,
    input wire logic actuator_present,
    input wire logic [CODE_W-1:0] actuator_code,
    input wire logic pair_request,
    output logic safety_output_pair,
    output logic switch_safe,
    output logic status_line,
    output logic frame_start,
    output logic pair_accepted,
    output logic pair_refused,
    output logic [PAIR_CNT_W-1:0] pairs_used
);

    typedef enum logic [0:0] {
        SW_UNSAFE,
        SW_SAFE
    } safe_e;

    // pin synchronisers: first stage feeds only the second
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= {pair_request, actuator_present, beyond_release, in_operating_range};
            pin_s2_r <= pin_s1_r;
        end
    end
    wire in_range_s = pin_s2_r[0];
    wire beyond_s = pin_s2_r[1];
    wire present_s = pin_s2_r[2];
    wire pair_lvl_s = pin_s2_r[3];

    // code is held stable by the reader, so two plain stages line it up with present_s
    logic [CODE_W-1:0] code_s1_r;
    logic [CODE_W-1:0] code_s2_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            code_s1_r <= '0;
            code_s2_r <= '0;
        end else begin
            code_s1_r <= actuator_code;
            code_s2_r <= code_s1_r;
        end
    end

    logic pair_lvl_d_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pair_lvl_d_r <= 1'b0;
        end else begin
            pair_lvl_d_r <= pair_lvl_s;
        end
    end
    wire pair_pulse = pair_lvl_s && !pair_lvl_d_r;

    // code store
    pair_if pif ();
    assign pif.req = pair_pulse && present_s;
    assign pif.code = code_s2_r;

    code_store #(
        .FACTORY_CODE(FACTORY_CODE)
    ) u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .variant(variant),
        .pif(pif)
    );

    // recognition: generic variant needs no pairing
    wire generic_ok = (variant == VAR_GENERIC) && (code_s2_r == GENERIC_CODE);
    wire paired_ok = (variant != VAR_GENERIC) && (code_s2_r == pif.stored);
    wire recognised = present_s && (generic_ok || paired_ok);

    // safe/unsafe; between ranges keep last decision (hysteresis)
    safe_e state_r;
    safe_e state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SW_SAFE: begin
                if (beyond_s || !recognised) begin
                    state_nxt = SW_UNSAFE;
                end
            end
            SW_UNSAFE: begin
                if (in_range_s && !beyond_s && recognised) begin
                    state_nxt = SW_SAFE;
                end
            end
            default: state_nxt = SW_UNSAFE;
        endcase
    end

    logic out_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= SW_UNSAFE;
            out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            out_r <= (state_nxt == SW_SAFE) && !beyond_s;
        end
    end
    assign safety_output_pair = out_r;
    assign switch_safe = (state_r == SW_SAFE);

    // status frame: diagnostic only, never read back by the safety path
    localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYCLES - 1);
    localparam logic [POS_W-1:0] FRAME_LAST = POS_W'(FRAME_SLOTS - 1);

    function automatic logic [POS_W-1:0] lower_pos(input logic [POS_W-1:0] a,
                                                  input logic [POS_W-1:0] b);
        lower_pos = (a < b) ? a : b;
    endfunction : lower_pos

    logic [SLOT_CNT_W-1:0] slot_cnt_r;
    logic [POS_W-1:0] slot_r;
    logic [POS_W-1:0] low_until_r;
    logic low_any_r;
    logic line_r;
    logic fstart_r;

    wire slot_end = (slot_cnt_r == SLOT_LAST);
    wire frame_end = slot_end && (slot_r == FRAME_LAST);
    wire own_unsafe = (state_r != SW_SAFE);
    // the first unsafe switch in chain order sets how long the line stays low
    wire [POS_W-1:0] first_pos =
        (own_unsafe && upstream_unsafe) ? lower_pos(chain_pos, upstream_unsafe_pos) :
        own_unsafe ? chain_pos : upstream_unsafe_pos;
    wire any_unsafe = own_unsafe || upstream_unsafe;
    wire [POS_W-1:0] slot_nxt = frame_end ? 5'h00 : (slot_end ? slot_r + 5'h01 : slot_r);
    wire line_nxt = !(low_any_r && (slot_nxt <= low_until_r));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slot_cnt_r <= '0;
            slot_r <= 5'h00;
            low_until_r <= 5'h00;
            low_any_r <= 1'b0;
            line_r <= 1'b1;
            fstart_r <= 1'b0;
        end else begin
            slot_cnt_r <= slot_end ? '0 : slot_cnt_r + 24'h000001;
            slot_r <= slot_nxt;
            fstart_r <= frame_end;
            if (frame_end) begin
                // latch pattern once per frame so a frame is self-consistent
                low_until_r <= first_pos;
                low_any_r <= any_unsafe;
            end
            line_r <= frame_end ? !(any_unsafe) : line_nxt;
        end
    end

    assign status_line = line_r;
    assign frame_start = fstart_r;
    assign pair_accepted = pif.accepted;
    assign pair_refused = pif.refused;
    assign pairs_used = pif.count;

    chk_release_off: assert property (@(posedge clk_sys) disable iff (rst)
        beyond_s |=> !safety_output_pair)
        else $error("safety outputs on beyond release");
    chk_unsafe_low_start: assert property (@(posedge clk_sys) disable iff (rst)
        (frame_end && any_unsafe) |=> !status_line)
        else $error("status line high at start of unsafe frame");
    chk_safe_frame_high: assert property (@(posedge clk_sys) disable iff (rst)
        (frame_end && !any_unsafe) |=> status_line [*2])
        else $error("status line low in all-safe frame");
    chk_frame_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        slot_r <= FRAME_LAST)
        else $error("slot index beyond chain length");
    chk_safe_needs_range: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(switch_safe) |-> $past(in_range_s && recognised))
        else $error("became safe outside operating range");
    chk_generic_no_pair: assert property (@(posedge clk_sys) disable iff (rst)
        (variant == VAR_GENERIC && pif.req) |=> pair_refused)
        else $error("generic variant took a pairing");
    chk_frame_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        frame_end |=> frame_start)
        else $error("no frame start after frame end");
    chk_pair_exclusive: assert property (@(posedge clk_sys) disable iff (rst)
        !(pair_accepted && pair_refused))
        else $error("pairing both accepted and refused");

endmodule : chain_status

`default_nettype wire

/* File: chain_pkg.sv */
/*
 * Shared constants for the chained status line and actuator pairing logic.
 * Assumes one 200 MHz clock and an active-high asynchronous reset.
 */
`default_nettype none

package chain_pkg;

    localparam int MAX_CHAIN = 16;
    localparam int POS_W = 5;
    localparam int CODE_W = 32;
    localparam int PAIR_CNT_W = 2;
    localparam logic [PAIR_CNT_W-1:0] PAIR_LIMIT = 2'h3;
    localparam logic [PAIR_CNT_W-1:0] PAIR_CNT_RST = 2'h0;
    localparam int CLK_MHZ = 200;
    localparam int SLOT_US = 100;
    localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int SLOT_CNT_W = 24;

    typedef enum logic [1:0] {
        VAR_FIXED,
        VAR_LIMITED,
        VAR_UNLIMITED,
        VAR_GENERIC
    } variant_e;

endpackage : chain_pkg

`default_nettype wire

/* File: pair_if.sv */
/*
 * Carries the pairing request and result between the top and the code store.
 * Assumes both ends share clk_sys.
 */
`default_nettype none

interface pair_if;
    import chain_pkg::*;
    logic req;
    logic [CODE_W-1:0] code;
    logic accepted;
    logic refused;
    logic [CODE_W-1:0] stored;
    logic [PAIR_CNT_W-1:0] count;
    modport store (input req, input code, output accepted, output refused, output stored,
        output count);
    modport user (output req, output code, input accepted, input refused, input stored,
        input count);
endinterface : pair_if

`default_nettype wire

/* File: code_store.sv */
/*
 * Stored actuator code with per-variant pairing policy.
 * Assumes req is a single-cycle pulse on the clk_sys domain.
 */
`default_nettype none

module code_store
    import chain_pkg::*;
#(
    parameter logic [CODE_W-1:0] FACTORY_CODE = 32'h5a5a_0001 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire variant_e variant,
    pair_if.store pif
);

    logic [CODE_W-1:0] code_r;
    logic [PAIR_CNT_W-1:0] count_r;
    logic accepted_r;
    logic refused_r;
    wire limit_hit = (count_r == PAIR_LIMIT);
    wire allow = (variant == VAR_UNLIMITED) ||
                 ((variant == VAR_LIMITED) && !limit_hit);
    // fixed and generic never pair
    wire take = pif.req && allow;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            code_r <= 32'h0000_0000;
            count_r <= PAIR_CNT_RST;
            accepted_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            accepted_r <= take;
            refused_r <= pif.req && !allow;
            if (take) begin
                code_r <= pif.code;
            end
            if (take && variant == VAR_LIMITED) begin
                count_r <= count_r + 2'h1;
            end
        end
    end

    // paired_r low marks "factory code still in force"; reset clears it rather than loading the parameter into code_r
    logic paired_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            paired_r <= 1'b0;
        end else if (take) begin
            paired_r <= 1'b1;
        end
    end

    assign pif.stored = paired_r ? code_r : FACTORY_CODE;
    assign pif.count = count_r;
    assign pif.accepted = accepted_r;
    assign pif.refused = refused_r;

    chk_limit_never_pass: assert property (@(posedge clk_sys) disable iff (rst)
        (pif.req && variant == VAR_LIMITED && limit_hit) |=> (!accepted_r && refused_r))
        else $error("pairing accepted past limit");
    chk_fixed_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        (pif.req && variant == VAR_FIXED) |=> (refused_r && $stable(pif.stored)))
        else $error("fixed variant changed code");
    chk_unlim_accept: assert property (@(posedge clk_sys) disable iff (rst)
        (pif.req && variant == VAR_UNLIMITED) |=> accepted_r)
        else $error("unlimited variant refused pairing");
    chk_overwrite_code: assert property (@(posedge clk_sys) disable iff (rst)
        take |=> (pif.stored == $past(pif.code)))
        else $error("stored code not overwritten");

endmodule : code_store

`default_nettype wire

/* File: status_reader.sv */
/*
 * Monitoring controller model that reads the chained diagnostic status line.
 * Assumes status_line and frame_start are registered on clk_sys.
 */
`default_nettype none

module status_reader (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic status_line,
    input wire logic frame_start,
    output var int low_cnt,
    output var int frames
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_cnt;
    // only counts low cycles and frames; nothing here gates a safety path
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_cnt <= 0;
            low_cnt <= 0;
            frames <= 0;
        end else if (frame_start) begin
            low_cnt <= run_cnt;
            run_cnt <= int'(!status_line);
            frames <= frames + 1;
        end else begin
            run_cnt <= run_cnt + int'(!status_line);
        end
    end
endmodule : status_reader

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for one chained switch: status frames, safety outputs, pairing.
 * Assumes chain_pkg and the design files are compiled first.
 */
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module tb import chain_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLOT = 4;
    localparam int NSLOT = 4;
    localparam logic [CODE_W-1:0] FCODE = 32'h1234_0001; // arbitrary value
    localparam logic [CODE_W-1:0] GCODE = 32'h0fed_0002; // arbitrary value
    logic clk_sys, rst, up_unsafe, in_range, beyond, present, pair_req;
    variant_e variant;
    logic [POS_W-1:0] chain_pos, up_pos;
    logic [CODE_W-1:0] act_code;
    logic sop, safe, line, fstart, acc, refd;
    logic [PAIR_CNT_W-1:0] used;
    int low_cnt, frames, miscompares, num_checks, cycles;

    chain_status #(.SLOT_CYCLES(SLOT), .FRAME_SLOTS(NSLOT), .FACTORY_CODE(FCODE),
        .GENERIC_CODE(GCODE)) u_dut (.clk_sys(clk_sys), .rst(rst), .variant(variant),
        .chain_pos(chain_pos), .upstream_unsafe_pos(up_pos), .upstream_unsafe(up_unsafe),
        .in_operating_range(in_range), .beyond_release(beyond), .actuator_present(present),
        .actuator_code(act_code), .pair_request(pair_req), .safety_output_pair(sop),
        .switch_safe(safe), .status_line(line), .frame_start(fstart),
        .pair_accepted(acc), .pair_refused(refd), .pairs_used(used));
    status_reader u_reader (.clk_sys(clk_sys), .rst(rst), .status_line(line),
        .frame_start(fstart), .low_cnt(low_cnt), .frames(frames));

    initial begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // budget covers every frame wait with a wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic restart(input variant_e v);
        rst = 1;
        variant = v;
        tick(3);
        rst = 0;
        tick(1);
    endtask : restart

    task automatic wait_safe(input logic e);
        for (int i = 0; i < 10 && safe !== e; i++) tick(1);
        `CHK("switch_safe", e, safe)
    endtask : wait_safe

    task automatic pair(input logic [CODE_W-1:0] c, input logic e);
        logic a, r;
        a = 0;
        r = 0;
        act_code = c;
        pair_req = 1;
        repeat (8) begin
            tick(1);
            a = a | acc;
            r = r | refd;
        end
        pair_req = 0;
        tick(4);
        `CHK("pair_accepted", e, a)
        `CHK("pair_refused", !e, r)
    endtask : pair

    task automatic t_safety;
        act_code = FCODE;
        in_range = 1;
        wait_safe(1);
        `CHK("safety_output_pair", 1'b1, sop)
        in_range = 0;
        beyond = 1;
        tick(3);
        `CHK("safety_output_pair", 1'b0, sop)
        wait_safe(0);
    endtask : t_safety

    // latched state shows only in the frame after the change
    task automatic t_frame(input int pos, input logic self_bad, input logic up,
        input int upp, input int slots);
        int f0;
        chain_pos = POS_W'(pos);
        up_pos = POS_W'(upp);
        up_unsafe = up;
        in_range = !self_bad;
        beyond = self_bad;
        f0 = frames;
        for (int i = 0; i < 300 && frames < f0 + 3; i++) tick(1);
        `CHK("frames", f0 + 3, frames)
        `CHK("low_cycles", slots * SLOT, low_cnt)
    endtask : t_frame

    task automatic t_variants;
        restart(VAR_FIXED);
        pair(32'h2222_0003, 0);
        act_code = FCODE;
        wait_safe(1);
        restart(VAR_LIMITED);
        // every pairing uses a fresh blank actuator code
        for (int k = 1; k <= 3; k++) begin
            pair(32'h3000_0000 + k, 1);
            `CHK("pairs_used", PAIR_CNT_W'(k), used)
        end
        pair(32'h3000_0009, 0);
        `CHK("pairs_used", PAIR_LIMIT, used)
        act_code = 32'h3000_0003;
        wait_safe(1);
        act_code = FCODE;
        wait_safe(0);
        restart(VAR_UNLIMITED);
        for (int k = 0; k < 5; k++) pair(32'h4000_0000 + k, 1);
        restart(VAR_GENERIC);
        act_code = GCODE;
        wait_safe(1);
        pair(32'h5000_0001, 0);
        act_code = FCODE;
        wait_safe(0);
    endtask : t_variants

    initial begin
        rst = 1;
        variant = VAR_FIXED;
        chain_pos = '0;
        up_pos = '0;
        up_unsafe = 0;
        in_range = 0;
        beyond = 0;
        present = 1;
        act_code = FCODE;
        pair_req = 0;
        tick(2);
        `CHK("status_line", 1'b1, line)
        `CHK("safety_output_pair", 1'b0, sop)
        `CHK("pairs_used", PAIR_CNT_RST, used)
        tick(1);
        rst = 0;
        tick(1);
        t_safety();
        t_frame(2, 1, 0, 0, 3);
        t_frame(3, 1, 0, 0, 4);
        t_frame(3, 1, 1, 1, 2);
        t_frame(3, 0, 1, 0, 1);
        t_frame(1, 0, 0, 0, 0);
        t_variants();
        test_done();
    end
endmodule : tb

`default_nettype wire
